// *** rtl/dcs_regs.sv ***
// Code staging registers: pages, staged and active codes, load triggers
// Operation
// - Fast select set copies page writes to channel
// - Fast input page copies into staged code
// - Precision active page copies into active code
// - Precision select set forwards page writes
// - Fast soft load one moves staged to active
// - Soft load bit self clears, reads zero
// - Unmasked precision pin assertion loads active code
// - Masked precision pin assertion is ignored
// - Precision active code in 23:8, resets zero
// - Fast staged code feeds the pin load and soft load paths
// - Fast select register resets to zero
// - Fast active page copies into active code
// - Precision soft load one moves staged to active
// - Fast active code holds live code, resets zero
// - Precision staged code in 23:8, resets zero
`timescale 1ns/1ps
`include "dcs_consts.svh"

module dcs_regs
   import dcs_pkg::*;
(
   input  wire logic      clk_in,
   input  wire logic      rstn_in,
   input  wire dcs_addr_t reg_addr_in,
   input  wire dcs_word_t reg_wdata_in,
   input  wire logic      reg_wr_in,
   input  wire logic      reg_rd_in,
   output dcs_word_t      reg_rdata_out,
   input  wire logic      load_code_pin_n_in,
   output dcs_code_t      fast_code_out,
   output dcs_code_t      precision_code_out
);

   // ==========================================================
   // Register state
   logic      fast_copy_select;
   logic      fast_load_pin_mask;
   dcs_code_t fast_input_page;
   dcs_code_t fast_active_page;
   dcs_code_t fast_staged_code;
   dcs_code_t fast_active_code;
   logic      precision_copy_select;
   logic      precision_load_pin_mask;
   dcs_code_t precision_input_page;
   dcs_code_t precision_active_page;
   dcs_code_t precision_staged_code;
   dcs_code_t precision_active_code;

   logic      next_fast_copy_select;
   logic      next_fast_load_pin_mask;
   dcs_code_t next_fast_input_page;
   dcs_code_t next_fast_active_page;
   dcs_code_t next_fast_staged_code;
   dcs_code_t next_fast_active_code;
   logic      next_precision_copy_select;
   logic      next_precision_load_pin_mask;
   dcs_code_t next_precision_input_page;
   dcs_code_t next_precision_active_page;
   dcs_code_t next_precision_staged_code;
   dcs_code_t next_precision_active_code;
   dcs_word_t next_rdata;

   logic      pin_load;
   logic      wr_fast;
   logic      wr_prec;
   dcs_code_t wr_prec_code;

   // ==========================================================
   // Load pin
   dcs_pin_sync u_pin_sync (
      .clk_in           (clk_in),
      .rstn_in          (rstn_in),
      .pin_n_in         (load_code_pin_n_in),
      .assert_pulse_out (pin_load)
   );

   assign wr_fast      = reg_wr_in;
   assign wr_prec      = reg_wr_in;
   // Only 23:8 of a precision word is code; low byte dropped on write
   assign wr_prec_code = reg_wdata_in[`DCS_PREC_MSB:`DCS_PREC_LSB];

   // ==========================================================
   // Fast mode next state
   always_comb begin
      next_fast_copy_select   = fast_copy_select;
      next_fast_load_pin_mask = fast_load_pin_mask;
      next_fast_input_page    = fast_input_page;
      next_fast_active_page   = fast_active_page;
      next_fast_staged_code   = fast_staged_code;
      next_fast_active_code   = fast_active_code;
      // Loads first, so a host write in the same cycle takes precedence
      if (pin_load && !fast_load_pin_mask) begin
         next_fast_active_code = fast_staged_code;
      end
      if (wr_fast) begin
         unique case (reg_addr_in)
            `DCS_ADDR_FAST_SELECT: begin
               next_fast_copy_select = reg_wdata_in[`DCS_SEL_BIT];
            end
            `DCS_ADDR_FAST_MASK: begin
               next_fast_load_pin_mask = reg_wdata_in[`DCS_MASK_BIT];
            end
            `DCS_ADDR_FAST_IN_PAGE: begin
               next_fast_input_page = reg_wdata_in[`DCS_FAST_MSB:`DCS_FAST_LSB];
               if (fast_copy_select) begin
                  next_fast_staged_code = reg_wdata_in[`DCS_FAST_MSB:`DCS_FAST_LSB];
               end
            end
            `DCS_ADDR_FAST_ACT_PAGE: begin
               next_fast_active_page = reg_wdata_in[`DCS_FAST_MSB:`DCS_FAST_LSB];
               if (fast_copy_select) begin
                  next_fast_active_code = reg_wdata_in[`DCS_FAST_MSB:`DCS_FAST_LSB];
               end
            end
            `DCS_ADDR_FAST_SOFT_LOAD: begin
               if (reg_wdata_in[`DCS_TRIG_BIT]) begin
                  next_fast_active_code = fast_staged_code;
               end
            end
            `DCS_ADDR_FAST_STAGED: begin
               next_fast_staged_code = reg_wdata_in[`DCS_FAST_MSB:`DCS_FAST_LSB];
            end
            `DCS_ADDR_FAST_ACTIVE: begin
               next_fast_active_code = reg_wdata_in[`DCS_FAST_MSB:`DCS_FAST_LSB];
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Precision mode next state
   always_comb begin
      next_precision_copy_select   = precision_copy_select;
      next_precision_load_pin_mask = precision_load_pin_mask;
      next_precision_input_page    = precision_input_page;
      next_precision_active_page   = precision_active_page;
      next_precision_staged_code   = precision_staged_code;
      next_precision_active_code   = precision_active_code;
      if (pin_load && !precision_load_pin_mask) begin
         next_precision_active_code = precision_staged_code;
      end
      if (wr_prec) begin
         unique case (reg_addr_in)
            `DCS_ADDR_PREC_SELECT: begin
               next_precision_copy_select = reg_wdata_in[`DCS_SEL_BIT];
            end
            `DCS_ADDR_PREC_MASK: begin
               next_precision_load_pin_mask = reg_wdata_in[`DCS_MASK_BIT];
            end
            `DCS_ADDR_PREC_IN_PAGE: begin
               next_precision_input_page = wr_prec_code;
               if (precision_copy_select) begin
                  next_precision_staged_code = wr_prec_code;
               end
            end
            `DCS_ADDR_PREC_ACT_PAGE: begin
               next_precision_active_page = wr_prec_code;
               if (precision_copy_select) begin
                  next_precision_active_code = wr_prec_code;
               end
            end
            `DCS_ADDR_PREC_SOFT_LOAD: begin
               if (reg_wdata_in[`DCS_TRIG_BIT]) begin
                  next_precision_active_code = precision_staged_code;
               end
            end
            `DCS_ADDR_PREC_STAGED: begin
               next_precision_staged_code = wr_prec_code;
            end
            `DCS_ADDR_PREC_ACTIVE: begin
               next_precision_active_code = wr_prec_code;
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Read mux, registered; unmapped offsets answer zero
   always_comb begin
      next_rdata = `DCS_WORD_RST;
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            `DCS_ADDR_FAST_SELECT:
               next_rdata[`DCS_SEL_BIT] = fast_copy_select;
            `DCS_ADDR_FAST_MASK:
               next_rdata[`DCS_MASK_BIT] = fast_load_pin_mask;
            `DCS_ADDR_FAST_IN_PAGE:
               next_rdata[`DCS_FAST_MSB:`DCS_FAST_LSB] = fast_input_page;
            `DCS_ADDR_FAST_ACT_PAGE:
               next_rdata[`DCS_FAST_MSB:`DCS_FAST_LSB] = fast_active_page;
            `DCS_ADDR_FAST_STAGED:
               next_rdata[`DCS_FAST_MSB:`DCS_FAST_LSB] = fast_staged_code;
            `DCS_ADDR_FAST_ACTIVE:
               next_rdata[`DCS_FAST_MSB:`DCS_FAST_LSB] = fast_active_code;
            `DCS_ADDR_PREC_SELECT:
               next_rdata[`DCS_SEL_BIT] = precision_copy_select;
            `DCS_ADDR_PREC_MASK:
               next_rdata[`DCS_MASK_BIT] = precision_load_pin_mask;
            `DCS_ADDR_PREC_IN_PAGE:
               next_rdata[`DCS_PREC_MSB:`DCS_PREC_LSB] = precision_input_page;
            `DCS_ADDR_PREC_ACT_PAGE:
               next_rdata[`DCS_PREC_MSB:`DCS_PREC_LSB] = precision_active_page;
            `DCS_ADDR_PREC_STAGED:
               next_rdata[`DCS_PREC_MSB:`DCS_PREC_LSB] = precision_staged_code;
            `DCS_ADDR_PREC_ACTIVE:
               next_rdata[`DCS_PREC_MSB:`DCS_PREC_LSB] = precision_active_code;
            // Trigger bits are never stored, so they read back as zero
            default:
               next_rdata = `DCS_WORD_RST;
         endcase
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         fast_copy_select        <= `DCS_BIT_RST;
         fast_load_pin_mask      <= `DCS_BIT_RST;
         fast_input_page         <= `DCS_CODE_RST;
         fast_active_page        <= `DCS_CODE_RST;
         fast_staged_code        <= `DCS_CODE_RST;
         fast_active_code        <= `DCS_CODE_RST;
         precision_copy_select   <= `DCS_BIT_RST;
         precision_load_pin_mask <= `DCS_BIT_RST;
         precision_input_page    <= `DCS_CODE_RST;
         precision_active_page   <= `DCS_CODE_RST;
         precision_staged_code   <= `DCS_CODE_RST;
         precision_active_code   <= `DCS_CODE_RST;
         reg_rdata_out           <= `DCS_WORD_RST;
      end else begin
         fast_copy_select        <= next_fast_copy_select;
         fast_load_pin_mask      <= next_fast_load_pin_mask;
         fast_input_page         <= next_fast_input_page;
         fast_active_page        <= next_fast_active_page;
         fast_staged_code        <= next_fast_staged_code;
         fast_active_code        <= next_fast_active_code;
         precision_copy_select   <= next_precision_copy_select;
         precision_load_pin_mask <= next_precision_load_pin_mask;
         precision_input_page    <= next_precision_input_page;
         precision_active_page   <= next_precision_active_page;
         precision_staged_code   <= next_precision_staged_code;
         precision_active_code   <= next_precision_active_code;
         reg_rdata_out           <= next_rdata;
      end
   end

   assign fast_code_out      = fast_active_code;
   assign precision_code_out = precision_active_code;

endmodule

// *** shared/dcs_consts.svh ***
// Offsets, field positions and reset values of the code staging registers
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH

// ==========================================================
// Register offsets
`define DCS_ADDR_FAST_MASK        8'h28
`define DCS_ADDR_FAST_ACTIVE      8'h29
`define DCS_ADDR_FAST_ACT_PAGE    8'h2d
`define DCS_ADDR_FAST_SELECT      8'h2f
`define DCS_ADDR_FAST_IN_PAGE     8'h30
`define DCS_ADDR_FAST_SOFT_LOAD   8'h32
`define DCS_ADDR_FAST_STAGED      8'h33
`define DCS_ADDR_PREC_MASK        8'h37
`define DCS_ADDR_PREC_ACTIVE      8'h38
`define DCS_ADDR_PREC_ACT_PAGE    8'h3e
`define DCS_ADDR_PREC_SELECT      8'h41
`define DCS_ADDR_PREC_IN_PAGE     8'h42
`define DCS_ADDR_PREC_SOFT_LOAD   8'h45
`define DCS_ADDR_PREC_STAGED      8'h46

// ==========================================================
// Field positions
`define DCS_SEL_BIT               0
`define DCS_TRIG_BIT              0
`define DCS_MASK_BIT              0
`define DCS_FAST_MSB              15
`define DCS_FAST_LSB              0
`define DCS_PREC_MSB              23
`define DCS_PREC_LSB              8

// ==========================================================
// Reset values
`define DCS_CODE_RST              16'h0000
`define DCS_BIT_RST               1'h0
`define DCS_WORD_RST              24'h000000
`define DCS_PIN_IDLE              1'h1

`endif

// *** shared/dcs_pkg.sv ***
// Types shared by the code staging register files
package dcs_pkg;
   typedef logic [15:0] dcs_code_t;
   typedef logic [23:0] dcs_word_t;
   typedef logic [7:0]  dcs_addr_t;
endpackage

// *** rtl/dcs_pin_sync.sv ***
// Three-stage synchroniser and assertion detector for the active-low load pin
`timescale 1ns/1ps
`include "dcs_consts.svh"

module dcs_pin_sync
   import dcs_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rstn_in,
   input  wire logic pin_n_in,
   output logic      assert_pulse_out
);

   // ==========================================================
   // State
   logic ff1;
   logic ff2;
   logic ff3;
   logic level;
   logic next_level;
   logic next_pulse;

   // ==========================================================
   // Filter: level moves only when stages two and three agree
   always_comb begin
      next_level = level;
      if (ff2 == ff3) begin
         next_level = ff3;
      end
      next_pulse = level & ~next_level;
   end

   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         ff1              <= `DCS_PIN_IDLE;
         ff2              <= `DCS_PIN_IDLE;
         ff3              <= `DCS_PIN_IDLE;
         level            <= `DCS_PIN_IDLE;
         assert_pulse_out <= `DCS_BIT_RST;
      end else begin
         ff1              <= pin_n_in;
         ff2              <= ff1;
         ff3              <= ff2;
         level            <= next_level;
         assert_pulse_out <= next_pulse;
      end
   end

endmodule

// *** tb/dcs_regs_asserts.sv ***
// Port checks for the code staging registers
`timescale 1ns/1ps
module dcs_regs_asserts
   import dcs_pkg::*;
(
   input wire logic      clk_in,
   input wire logic      rstn_in,
   input wire dcs_addr_t reg_addr_in,
   input wire dcs_word_t reg_wdata_in,
   input wire logic      reg_wr_in,
   input wire logic      reg_rd_in,
   input wire dcs_word_t reg_rdata_out,
   input wire logic      load_code_pin_n_in,
   input wire dcs_code_t fast_code_out,
   input wire dcs_code_t precision_code_out
);
   // ==========
   // Cycles since pin low; pin loads land late, so changes need slack
   logic [2:0] quiet_cnt;
   logic [2:0] next_quiet_cnt;
   always_comb begin
      next_quiet_cnt = quiet_cnt;
      if (!rstn_in || !load_code_pin_n_in) begin
         next_quiet_cnt = 3'h0;
      end else if (quiet_cnt != 3'h7) begin
         next_quiet_cnt = quiet_cnt + 3'h1;
      end
   end
   always_ff @(posedge clk_in) begin
      quiet_cnt <= next_quiet_cnt;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // ==========
   // Properties
   property p_rd_zero;
      reg_rd_in && reg_addr_in inside {8'h32, 8'h45, 8'h50} |=> reg_rdata_out == 24'h0;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("trigger read not zero");
   property p_low_byte;
      reg_rd_in && reg_addr_in == 8'h38 |=> reg_rdata_out[7:0] == 8'h00;
   endproperty
   a_low_byte: assert property (p_low_byte) else $error("low byte not zero");
   property p_idle;
      !reg_rd_in |=> reg_rdata_out == 24'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("read data without read");
   // No local variables: the past write word is masked to the code field instead
   property p_wr_fast;
      reg_wr_in && reg_addr_in == 8'h29
         |=> {8'h00, fast_code_out} == ($past(reg_wdata_in) & 24'h00ffff);
   endproperty
   a_wr_fast: assert property (p_wr_fast) else $error("fast code write lost");
   property p_wr_prec;
      reg_wr_in && reg_addr_in == 8'h38
         |=> {precision_code_out, 8'h00} == ($past(reg_wdata_in) & 24'hffff00);
   endproperty
   a_wr_prec: assert property (p_wr_prec) else $error("precision write lost");
   property p_soft_zero;
      reg_wr_in && reg_addr_in == 8'h32 && !reg_wdata_in[0] && quiet_cnt >= 3'h6
         |=> $stable(fast_code_out);
   endproperty
   a_soft_zero: assert property (p_soft_zero) else $error("zero trigger moved code");
   property p_rst;
      @(posedge clk_in) disable iff (1'b0)
      !rstn_in |=> fast_code_out == 16'h0 && precision_code_out == 16'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("codes not zero in reset");
   property p_cause;
      !$stable(precision_code_out) |-> $past(reg_wr_in) || quiet_cnt < 3'h6;
   endproperty
   a_cause: assert property (p_cause) else $error("code moved with no cause");
   c_soft: cover property (reg_wr_in && reg_addr_in == 8'h32 && reg_wdata_in[0]);
   c_pin: cover property ($fell(load_code_pin_n_in));
   c_rd: cover property (reg_rd_in && reg_addr_in == 8'h38);
endmodule

// *** tb/dcs_host.sv ***
// Host model: register accesses and load pin pulses
`timescale 1ns/1ps
module dcs_host
   import dcs_pkg::*;
(
   input  wire logic      clk_in,
   input  wire dcs_word_t reg_rdata_in,
   output dcs_addr_t      reg_addr_out,
   output dcs_word_t      reg_wdata_out,
   output logic           reg_wr_out,
   output logic           reg_rd_out,
   output logic           load_code_pin_n_out
);
   initial begin
      reg_addr_out = 8'h00;
      reg_wdata_out = 24'h000000;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      load_code_pin_n_out = 1'b1;
   end
   // Released bus shows inverted values; each read inverts wdata again, so one read after a write restores the last written word
   task automatic drop();
      reg_addr_out = ~reg_addr_out;
      reg_wdata_out = ~reg_wdata_out;
   endtask
   // Trigger writes carry bit 0 as given by the caller
   task automatic write_reg(input dcs_addr_t a, input dcs_word_t d);
      @(negedge clk_in);
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = 1'b1;
      @(negedge clk_in);
      reg_wr_out = 1'b0;
      drop();
   endtask
   task automatic read_reg(input dcs_addr_t a, output dcs_word_t q);
      @(negedge clk_in);
      reg_addr_out = a;
      reg_rd_out = 1'b1;
      @(negedge clk_in);
      reg_rd_out = 1'b0;
      drop();
      q = reg_rdata_in;
   endtask
   // Low 3 cycles, high 8: meets spacing and covers sync delay
   task automatic pulse_pin();
      @(negedge clk_in);
      load_code_pin_n_out = 1'b0;
      repeat (3) @(negedge clk_in);
      load_code_pin_n_out = 1'b1;
      repeat (8) @(negedge clk_in);
   endtask
endmodule

// *** tb/dac_code_staging_registers_tb.sv ***
// Directed bench for the code staging registers
`timescale 1ns/1ps
module dac_code_staging_registers_tb import dcs_pkg::*; ;
   logic      clk_in = 1'b0;
   logic      rstn_in = 1'b0;
   dcs_addr_t addr;
   dcs_word_t wdata;
   dcs_word_t rdata;
   dcs_word_t q;
   logic      wr;
   logic      rd;
   logic      pin_n;
   dcs_code_t fcode;
   dcs_code_t pcode;
   int        bad_count = 0;
   int        compares = 0;
   dcs_addr_t rst_list[8] = '{8'h28, 8'h29, 8'h2f, 8'h33, 8'h37, 8'h38, 8'h41, 8'h46};
   always #12.5 clk_in = ~clk_in;
   dcs_host HOST (.clk_in(clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
      .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd), .load_code_pin_n_out(pin_n));
   dcs_regs DUT (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .load_code_pin_n_in(pin_n), .fast_code_out(fcode), .precision_code_out(pcode));
   // ==========
   // Compare and finish
   task automatic chk(input dcs_word_t seen, input dcs_word_t exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input dcs_addr_t a, input dcs_word_t exp);
      HOST.read_reg(a, q);
      chk(q, exp);
   endtask
   task automatic end_sim();
      if (bad_count == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ==========
   // Tests
   initial begin
      repeat (16) @(negedge clk_in);
      rstn_in = 1'b1;
      foreach (rst_list[i]) rchk(rst_list[i], 24'h000000);
      HOST.write_reg(8'h30, 24'h001234);
      rchk(8'h33, 24'h000000);
      rchk(8'h30, 24'h001234);
      HOST.write_reg(8'h2f, 24'h0000ff);
      rchk(8'h2f, 24'h000001);
      HOST.write_reg(8'h30, 24'h00abcd);
      rchk(8'h33, 24'h00abcd);
      chk({8'h00, fcode}, 24'h000000);
      HOST.write_reg(8'h2d, 24'h005a5a);
      chk({8'h00, fcode}, 24'h005a5a);
      HOST.write_reg(8'h32, 24'h0000fe);
      chk({8'h00, fcode}, 24'h005a5a);
      HOST.write_reg(8'h32, 24'h000001);
      chk({8'h00, fcode}, 24'h00abcd);
      rchk(8'h32, 24'h000000);
      HOST.write_reg(8'h41, 24'h000001);
      HOST.write_reg(8'h42, 24'h1234ff);
      rchk(8'h46, 24'h123400);
      HOST.write_reg(8'h3e, 24'hbeef77);
      chk({8'h00, pcode}, 24'h00beef);
      rchk(8'h38, 24'hbeef00);
      HOST.write_reg(8'h45, 24'h000001);
      chk({8'h00, pcode}, 24'h001234);
      rchk(8'h45, 24'h000000);
      HOST.write_reg(8'h46, 24'h777700);
      HOST.write_reg(8'h28, 24'h000001);
      HOST.write_reg(8'h37, 24'h000001);
      HOST.pulse_pin();
      chk({8'h00, pcode}, 24'h001234);
      chk({8'h00, fcode}, 24'h00abcd);
      HOST.write_reg(8'h37, 24'h000000);
      HOST.pulse_pin();
      chk({8'h00, pcode}, 24'h007777);
      HOST.write_reg(8'h28, 24'h000000);
      HOST.write_reg(8'h33, 24'hff4321);
      rchk(8'h33, 24'h004321);
      HOST.pulse_pin();
      chk({8'h00, fcode}, 24'h004321);
      HOST.write_reg(8'h50, 24'hffffff);
      rchk(8'h50, 24'h000000);
      // Direct writes to the active codes
      HOST.write_reg(8'h29, 24'hff1111);
      chk({8'h00, fcode}, 24'h001111);
      HOST.write_reg(8'h38, 24'h2222ff);
      chk({8'h00, pcode}, 24'h002222);
      rchk(8'h38, 24'h222200);
      // Selects cleared: page writes must not copy
      HOST.write_reg(8'h2f, 24'h000000);
      HOST.write_reg(8'h41, 24'h000000);
      HOST.write_reg(8'h2d, 24'h003333);
      chk({8'h00, fcode}, 24'h001111);
      rchk(8'h2d, 24'h003333);
      HOST.write_reg(8'h30, 24'h004444);
      rchk(8'h33, 24'h004321);
      HOST.write_reg(8'h3e, 24'h5555aa);
      chk({8'h00, pcode}, 24'h002222);
      rchk(8'h3e, 24'h555500);
      HOST.write_reg(8'h42, 24'h6666aa);
      rchk(8'h46, 24'h777700);
      rchk(8'h42, 24'h666600);
      // Mid-run reset must clear loaded state
      @(negedge clk_in);
      rstn_in = 1'b0;
      repeat (2) @(negedge clk_in);
      rstn_in = 1'b1;
      chk({8'h00, fcode}, 24'h000000);
      chk({8'h00, pcode}, 24'h000000);
      rchk(8'h2f, 24'h000000);
      rchk(8'h33, 24'h000000);
      rchk(8'h46, 24'h000000);
      end_sim();
   end
   // Run needs well under 500 cycles; 4000 cycles means a hang
   initial begin
      #100000;
      bad_count++;
      end_sim();
   end
endmodule
bind dcs_regs dcs_regs_asserts CHK (.clk_in(clk_in), .rstn_in(rstn_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .load_code_pin_n_in(load_code_pin_n_in), .fast_code_out(fast_code_out),
   .precision_code_out(precision_code_out));
